// file: hw/fe_core.sv
// Front-end register file and PWM transmit summing, programmed over a 16-bit serial link
`timescale 1ns/10ps
`include "fe_defs.svh"
module fe_core (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Serial configuration link
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_mosi,
  // Control pins
  input wire logic shutdown_pin,
  input wire logic dac_mode_pin,
  // PWM tone inputs
  input wire logic pwm_a_in,
  input wire logic pwm_b_in,
  // Thermal sensor
  input wire logic thermal_overload,
  // Analog configuration
  output logic band_select_bit,
  output logic [1:0] transmit_gain_code,
  output logic [3:0] receive_gain_code,
  output logic [8:0] tx_gain_q8,
  output logic [1:0] bias_enable,
  output logic zero_cross_enable,
  output logic power_amp_enable,
  output logic transmit_enable,
  output logic converter_enable,
  // Transmit path
  output logic pwm_mode_active,
  output logic [1:0] tx_level,
  // Interrupt
  output logic thermal_flag,
  output logic interrupt_out
);

  // ****************************************
  // Link domain receiver
  // ****************************************
  frame_if fr ();

  spi_frame_rx u_rx (
    .link_sclk(link_sclk),
    .link_cs_n(link_cs_n),
    .link_mosi(link_mosi),
    .sys_rst(sys_rst),
    .fr(fr)
  );

  // ****************************************
  // State
  // ****************************************
  fe_pkg::core_s st_r;
  fe_pkg::core_s st_nxt;

  logic frame_evt;
  logic [15:0] frm;
  logic [6:0] frm_addr;
  logic [7:0] frm_data;
  logic frm_write;
  logic therm_evt;
  logic pwm_ok;
  logic [1:0] level_sum;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_nxt = st_r;

    // Two-stage synchronisers for every foreign input except the frame word
    st_nxt.tgl_s1 = fr.done_tgl;
    st_nxt.tgl_s2 = st_r.tgl_s1;
    st_nxt.tgl_s3 = st_r.tgl_s2;
    st_nxt.sd_s1 = shutdown_pin;
    st_nxt.sd_s2 = st_r.sd_s1;
    st_nxt.dac_s1 = dac_mode_pin;
    st_nxt.dac_s2 = st_r.dac_s1;
    st_nxt.pa_s1 = pwm_a_in;
    st_nxt.pa_s2 = st_r.pa_s1;
    st_nxt.pb_s1 = pwm_b_in;
    st_nxt.pb_s2 = st_r.pb_s1;
    st_nxt.th_s1 = thermal_overload;
    st_nxt.th_s2 = st_r.th_s1;
    st_nxt.th_s3 = st_r.th_s2;

    // Word is stable here: the next toggle needs a whole further character
    frame_evt = st_r.tgl_s2 ^ st_r.tgl_s3;
    frm = fr.word;
    frm_addr = frm[`FE_FRM_ADDR_HI:`FE_FRM_ADDR_LO];
    frm_data = frm[`FE_FRM_DATA_HI:`FE_FRM_DATA_LO];
    // Only register writes are decoded; no sample data path exists here
    frm_write = frame_evt & ~frm[`FE_FRM_READ];
    therm_evt = st_r.th_s2 & ~st_r.th_s3;

    // ****************************************
    // Register writes
    // ****************************************
    if (frm_write) begin
      unique case (frm_addr)
        `FE_ADDR_ENABLE1: begin
          st_nxt.enable1 = frm_data;
        end
        `FE_ADDR_GAIN: begin
          st_nxt.gain = frm_data;
        end
        `FE_ADDR_SECOND_ENABLE_REGISTER: begin
          st_nxt.second_enable_register = frm_data;
        end
        `FE_ADDR_FIRST_CONTROL_REGISTER: begin
          st_nxt.first_control_register = frm_data;
        end
        `FE_ADDR_SECOND_CONTROL_REGISTER: begin
          // Flag bits take the written value, so 0x00 clears everything unless a thermal event lands in the same cycle
          st_nxt.second_control_register = frm_data;
        end
        `FE_ADDR_RESET: begin
          if (frm_data == `FE_SOFT_RESET_CODE) begin
            st_nxt.enable1 = `FE_RST_ENABLE1;
            st_nxt.second_enable_register = `FE_RST_SECOND_ENABLE_REGISTER;
            st_nxt.gain = `FE_RST_GAIN;
            st_nxt.first_control_register = `FE_RST_FIRST_CONTROL_REGISTER;
            st_nxt.second_control_register = `FE_RST_SECOND_CONTROL_REGISTER;
          end
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // Thermal interrupt
    // ****************************************
    // A new event wins over a clearing write in the same cycle
    if (therm_evt) begin
      st_nxt.second_control_register[`FE_CTL2_THERM_FLAG] = 1'b1;
    end
    st_nxt.int_out = st_nxt.second_control_register[`FE_CTL2_THERM_FLAG] &
                     st_nxt.second_control_register[`FE_CTL2_THERM_EN];

    // ****************************************
    // Shutdown holds the register file in reset
    // ****************************************
    if (st_r.sd_s2) begin
      st_nxt.enable1 = `FE_RST_ENABLE1;
      st_nxt.second_enable_register = `FE_RST_SECOND_ENABLE_REGISTER;
      st_nxt.gain = `FE_RST_GAIN;
      st_nxt.first_control_register = `FE_RST_FIRST_CONTROL_REGISTER;
      st_nxt.second_control_register = `FE_RST_SECOND_CONTROL_REGISTER;
      st_nxt.int_out = 1'b0;
    end

    // ****************************************
    // Transmit gain factor
    // ****************************************
    unique case (st_nxt.gain[`FE_GAIN_TX_HI:`FE_GAIN_TX_LO])
      2'h0: st_nxt.tx_gain_q8 = `FE_TXG_Q8_0;
      2'h1: st_nxt.tx_gain_q8 = `FE_TXG_Q8_1;
      2'h2: st_nxt.tx_gain_q8 = `FE_TXG_Q8_2;
      2'h3: st_nxt.tx_gain_q8 = `FE_TXG_Q8_3;
    endcase

    // ****************************************
    // PWM transmit mode and summing
    // ****************************************
    pwm_ok = st_r.enable1[`FE_EN1_TX] & st_r.enable1[`FE_EN1_PA] &
             ~st_r.enable1[`FE_EN1_CONV] & ~st_r.dac_s2 & ~st_r.sd_s2;
    st_nxt.pwm_mode = pwm_ok;
    // The two tones are added; 66% and 33% duty give a three-level staircase
    level_sum = {1'b0, st_r.pa_s2} + {1'b0, st_r.pb_s2};
    st_nxt.tx_level = pwm_ok ? level_sum : 2'h0;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.enable1 <= `FE_RST_ENABLE1;
      st_r.second_enable_register <= `FE_RST_SECOND_ENABLE_REGISTER;
      st_r.gain <= `FE_RST_GAIN;
      st_r.first_control_register <= `FE_RST_FIRST_CONTROL_REGISTER;
      st_r.second_control_register <= `FE_RST_SECOND_CONTROL_REGISTER;
      st_r.tx_gain_q8 <= `FE_TXG_Q8_0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs, all straight from flip-flops
  // ****************************************
  assign band_select_bit = st_r.first_control_register[`FE_CTL1_BAND];
  assign transmit_gain_code = st_r.gain[`FE_GAIN_TX_HI:`FE_GAIN_TX_LO];
  assign receive_gain_code = st_r.gain[`FE_GAIN_RX_HI:`FE_GAIN_RX_LO];
  assign tx_gain_q8 = st_r.tx_gain_q8;
  assign bias_enable = st_r.second_enable_register[`FE_EN2_BIAS_HI:`FE_EN2_BIAS_LO];
  assign zero_cross_enable = st_r.second_enable_register[`FE_EN2_ZC];
  assign power_amp_enable = st_r.enable1[`FE_EN1_PA];
  assign transmit_enable = st_r.enable1[`FE_EN1_TX];
  assign converter_enable = st_r.enable1[`FE_EN1_CONV];
  assign pwm_mode_active = st_r.pwm_mode;
  assign tx_level = st_r.tx_level;
  assign thermal_flag = st_r.second_control_register[`FE_CTL2_THERM_FLAG];
  assign interrupt_out = st_r.int_out;

endmodule // fe_core

// file: hw/fe_defs.svh
// Offsets, field positions, reset values and codes of the front-end register file
`ifndef FE_DEFS_SVH
`define FE_DEFS_SVH

// ****************************************
// Frame layout (16-bit characters)
// ****************************************
`define FE_FRAME_BITS 16
`define FE_FRM_READ 15
`define FE_FRM_ADDR_HI 14
`define FE_FRM_ADDR_LO 8
`define FE_FRM_DATA_HI 7
`define FE_FRM_DATA_LO 0

// ****************************************
// Register offsets
// ****************************************
`define FE_ADDR_ENABLE1 7'h01
`define FE_ADDR_GAIN 7'h02
`define FE_ADDR_SECOND_ENABLE_REGISTER 7'h03
`define FE_ADDR_FIRST_CONTROL_REGISTER 7'h04
`define FE_ADDR_SECOND_CONTROL_REGISTER 7'h05
`define FE_ADDR_RESET 7'h09

// ****************************************
// Field positions
// ****************************************
`define FE_EN1_TX 0
`define FE_EN1_PA 1
`define FE_EN1_CONV 2
`define FE_EN2_BIAS_HI 1
`define FE_EN2_BIAS_LO 0
`define FE_EN2_ZC 2
`define FE_GAIN_RX_HI 3
`define FE_GAIN_RX_LO 0
`define FE_GAIN_TX_HI 5
`define FE_GAIN_TX_LO 4
`define FE_CTL1_BAND 0
`define FE_CTL2_THERM_EN 0
`define FE_CTL2_THERM_FLAG 4

// ****************************************
// Reset values and codes
// ****************************************
`define FE_RST_ENABLE1 8'h00
`define FE_RST_SECOND_ENABLE_REGISTER 8'h00
`define FE_RST_GAIN 8'h00
`define FE_RST_FIRST_CONTROL_REGISTER 8'h00
`define FE_RST_SECOND_CONTROL_REGISTER 8'h00
`define FE_SOFT_RESET_CODE 8'h14

// Transmit gain factors in units of 1/256 V/V
`define FE_TXG_Q8_0 9'h040
`define FE_TXG_Q8_1 9'h080
`define FE_TXG_Q8_2 9'h0B5
`define FE_TXG_Q8_3 9'h100

`endif

// file: hw/fe_pkg.sv
// Types shared by the front-end serial receiver and register core
package fe_pkg;

  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [14:0] shift;
  } rx_cnt_s;

  typedef struct packed {
    logic [15:0] word;
    logic done_tgl;
  } rx_hold_s;

  typedef struct packed {
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic sd_s1;
    logic sd_s2;
    logic dac_s1;
    logic dac_s2;
    logic pa_s1;
    logic pa_s2;
    logic pb_s1;
    logic pb_s2;
    logic th_s1;
    logic th_s2;
    logic th_s3;
    logic [7:0] enable1;
    logic [7:0] second_enable_register;
    logic [7:0] gain;
    logic [7:0] first_control_register;
    logic [7:0] second_control_register;
    logic [1:0] tx_level;
    logic pwm_mode;
    logic int_out;
    logic [8:0] tx_gain_q8;
  } core_s;

endpackage

// file: hw/frame_if.sv
// Hand-over of received serial frames from the link domain to the core
`timescale 1ns/10ps
interface frame_if;
  logic [15:0] word;
  logic done_tgl;

  modport rx (output word, output done_tgl);
  modport core (input word, input done_tgl);
endinterface

// file: hw/spi_frame_rx.sv
// Serial frame receiver running on the link clock
`timescale 1ns/10ps
module spi_frame_rx (
  // Link pins
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_mosi,
  // System reset
  input wire logic sys_rst,
  // Frame hand-over
  frame_if.rx fr
);

  fe_pkg::rx_cnt_s cnt_r;
  fe_pkg::rx_cnt_s cnt_nxt;
  fe_pkg::rx_hold_s hold_r;
  fe_pkg::rx_hold_s hold_nxt;
  logic frame_clr;

  // Deselect restarts character alignment; the link clock stands still then
  assign frame_clr = link_cs_n | sys_rst;

  // ****************************************
  // Shift in MSB first, 16 bits per character
  // ****************************************
  always_comb begin
    cnt_nxt = cnt_r;
    hold_nxt = hold_r;
    cnt_nxt.shift = {cnt_r.shift[13:0], link_mosi};
    cnt_nxt.bit_cnt = cnt_r.bit_cnt + 4'h1;
    if (cnt_r.bit_cnt == 4'hF) begin
      hold_nxt.word = {cnt_r.shift, link_mosi};
      hold_nxt.done_tgl = ~hold_r.done_tgl;
    end
  end

  always_ff @(posedge link_sclk or posedge frame_clr) begin
    if (frame_clr) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Held word stays stable for a whole character after each toggle
  always_ff @(posedge link_sclk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_r <= '0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  assign fr.word = hold_r.word;
  assign fr.done_tgl = hold_r.done_tgl;

endmodule // spi_frame_rx

// file: verification/fe_core_asserts.sv
// Port-level checks on the front-end core
`timescale 1ns/10ps
module fe_core_asserts (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Inputs
  input wire logic link_cs_n,
  input wire logic shutdown_pin,
  input wire logic dac_mode_pin,
  input wire logic pwm_a_in,
  input wire logic pwm_b_in,
  input wire logic thermal_overload,
  // Outputs
  input wire logic band_select_bit,
  input wire logic [1:0] transmit_gain_code,
  input wire logic [3:0] receive_gain_code,
  input wire logic [8:0] tx_gain_q8,
  input wire logic [1:0] bias_enable,
  input wire logic zero_cross_enable,
  input wire logic transmit_enable,
  input wire logic pwm_mode_active,
  input wire logic [1:0] tx_level,
  input wire logic thermal_flag,
  input wire logic interrupt_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire [10:0] cfg = {band_select_bit, transmit_gain_code, receive_gain_code, bias_enable, zero_cross_enable,
    transmit_enable};
  a_txg_map: assert property (tx_gain_q8 == (transmit_gain_code[1] ? (transmit_gain_code[0] ? 9'h100 : 9'h0B5) :
    (transmit_gain_code[0] ? 9'h080 : 9'h040))) else $error("gain factor wrong");
  a_level_max: assert property (tx_level != 2'h3) else $error("level out of range");
  a_level_idle: assert property (!pwm_mode_active && !$past(pwm_mode_active) |-> tx_level == 2'h0)
    else $error("level outside pwm mode");
  a_level_sum: assert property (pwm_mode_active [*5] |->
    tx_level == {1'b0, $past(pwm_a_in, 3)} + {1'b0, $past(pwm_b_in, 3)}) else $error("level not sum");
  a_mode_block: assert property ((dac_mode_pin || shutdown_pin) [*4] |-> !pwm_mode_active)
    else $error("pwm mode not blocked");
  a_shutdown_hold: assert property (shutdown_pin [*5] |-> cfg == 11'h000) else $error("not held");
  a_irq_flag: assert property (interrupt_out |-> thermal_flag) else $error("irq without flag");
  a_cfg_stable: assert property ((link_cs_n && !shutdown_pin) [*8] |-> $stable(cfg))
    else $error("config moved without frame");
  a_flag_hold: assert property ((link_cs_n && !shutdown_pin) [*8] ##0 thermal_flag |=> thermal_flag)
    else $error("flag dropped");
  a_therm_set: assert property ((!shutdown_pin) [*6] ##0 $rose(thermal_overload) |-> ##[2:6] thermal_flag)
    else $error("flag not set");
  cover property (pwm_mode_active && tx_level == 2'h2);
  cover property ($rose(thermal_flag));
  cover property (shutdown_pin [*5]);
endmodule // fe_core_asserts

// file: verification/host_model.sv
// Host model: serial register writer and packet tone source
`timescale 1ns/10ps
module host_model #(
  parameter int BIT_CLKS = 48
) (
  // System
  input wire logic clk,
  input wire logic tone_on,
  input wire logic packet_select,
  // Link pins
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_mosi,
  // Tone outputs
  output logic pwm_a_in,
  output logic pwm_b_in
);
  logic [2:0] ph_r = 3'h0;
  logic [5:0] clk_cnt_r = 6'h00;
  logic [7:0] bit_cnt_r = 8'h00;
  logic [10:0] word;
  logic mark;
  logic [2:0] per;
  // Code words, first element in the top bit; a one is mark
  assign word = packet_select ? 11'h0ED : 11'h712;
  assign mark = word[10 - bit_cnt_r % 11];
  // Tones scaled to this clock: mark three clocks, space six
  assign per = mark ? 3'h3 : 3'h6;
  initial begin
    link_sclk = 1'b0;
    // Late in time zero so the receiver sees the deselect edge
    link_cs_n <= 1'b1;
    link_mosi = 1'b1;
    pwm_a_in = 1'b0;
    pwm_b_in = 1'b0;
  end
  // Clock idles low; data inverted once released
  task automatic send(input logic [15:0] w, input int n);
    #7 link_cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      link_mosi = w[i];
      #32 link_sclk = 1'b1;
      #32 link_sclk = 1'b0;
    end
    #32 link_cs_n = 1'b1;
    link_mosi = ~link_mosi;
  endtask
  // Two thirds and one third duty at the tone rate; one bit per BIT_CLKS clocks
  always @(posedge clk) begin
    if (!tone_on) begin
      ph_r <= 3'h0;
      clk_cnt_r <= 6'h00;
      bit_cnt_r <= 8'h00;
      pwm_a_in <= 1'b0;
      pwm_b_in <= 1'b0;
    end else begin
      // Outputs quiet once the 33 packet bits are out
      pwm_a_in <= bit_cnt_r < 8'h21 && ph_r < (mark ? 3'h2 : 3'h4);
      pwm_b_in <= bit_cnt_r < 8'h21 && ph_r < (mark ? 3'h1 : 3'h2);
      // Retune at each bit boundary
      if (clk_cnt_r == 6'(BIT_CLKS - 1)) begin
        ph_r <= 3'h0;
        clk_cnt_r <= 6'h00;
        // Count would reach 209 here: start the packet again
        bit_cnt_r <= (bit_cnt_r == 8'hD0) ? 8'h00 : bit_cnt_r + 8'h01;
      end else begin
        ph_r <= (ph_r == per - 3'h1) ? 3'h0 : ph_r + 3'h1;
        clk_cnt_r <= clk_cnt_r + 6'h01;
      end
    end
  end
endmodule // host_model

// file: verification/testbench.sv
// Self-checking bench for the front-end core
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst;
  logic shutdown_pin = 1'b0;
  logic dac_mode_pin = 1'b0;
  logic thermal_overload = 1'b0;
  logic tone_on = 1'b0;
  logic packet_select = 1'b1;
  logic link_sclk, link_cs_n, link_mosi, pwm_a_in, pwm_b_in, band_select_bit, zero_cross_enable;
  logic power_amp_enable, transmit_enable, converter_enable, pwm_mode_active, thermal_flag, interrupt_out;
  logic [1:0] transmit_gain_code, bias_enable, tx_level;
  logic [3:0] receive_gain_code;
  logic [8:0] tx_gain_q8;
  int err_total = 0;
  int comparisons = 0;
  int n2;
  int n_run [3];
  logic [15:0] rows [16][2] = '{
    '{16'h0303, 16'h0030}, '{16'h0401, 16'h1030}, '{16'h0500, 16'h1030}, '{16'h0501, 16'h1030},
    '{16'h0307, 16'h1038}, '{16'h0230, 16'h1C38}, '{16'h0225, 16'h1978}, '{16'h021F, 16'h17F8},
    '{16'h0400, 16'h07F8}, '{16'h8401, 16'h07F8}, '{16'h7F01, 16'h07F8}, '{16'h0913, 16'h07F8},
    '{16'h0107, 16'h07FF}, '{16'h0103, 16'h27FB}, '{16'h0203, 16'h20FB}, '{16'h0914, 16'h0000}};
  wire [15:0] cfg = {2'h0, pwm_mode_active, band_select_bit, transmit_gain_code, receive_gain_code, bias_enable,
    zero_cross_enable, converter_enable, power_amp_enable, transmit_enable};
  always #25 clk = ~clk;
  host_model u_host (.*);
  fe_core u_dut (.*);
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] w);
    u_host.send(w, 16);
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  // Counts tone periods (starts of level 2) in three windows after tone on
  task automatic tone_run(input int w0, input int w1, input int w2);
    logic [1:0] lvl_prev;
    n_run = '{0, 0, 0};
    lvl_prev = 2'h0;
    @(posedge clk) tone_on <= 1'b1;
    for (int i = 0; i < w2; i++) begin
      @(negedge clk);
      if (tx_level === 2'h2 && lvl_prev !== 2'h2) begin
        n_run[(i < w0) ? 0 : ((i < w1) ? 1 : 2)]++;
      end
      lvl_prev = tx_level;
    end
    @(posedge clk) tone_on <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results;
  end
  initial begin
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check("reset", cfg, 16'h0000);
    check("q8", {7'h00, tx_gain_q8}, 16'h0040);
    for (int i = 0; i < 16; i++) begin
      wr(rows[i][0]);
      check("row", cfg, rows[i][1]);
    end
    // ****************************************
    // Hand-written cases
    // ****************************************
    wr(16'h0103);
    @(posedge clk) tone_on <= 1'b1;
    repeat (10) @(posedge clk);
    n2 = 0;
    repeat (30) begin
      @(negedge clk);
      n2 += (tx_level === 2'h2);
    end
    check("level", n2[15:0], 16'h000A);
    @(posedge clk) tone_on <= 1'b0;
    repeat (6) @(negedge clk);
    check("quiet", {14'h0, tx_level}, 16'h0000);
    @(posedge clk) dac_mode_pin <= 1'b1;
    repeat (5) @(negedge clk);
    check("dac", {15'h0, pwm_mode_active}, 16'h0000);
    @(posedge clk) dac_mode_pin <= 1'b0;
    repeat (5) @(negedge clk);
    check("pwm", {15'h0, pwm_mode_active}, 16'h0001);
    // Full cycle: 33 bits, quiet gap, first bit of the next packet
    tone_run(1600, 10036, 10084);
    check("packet", n_run[0][15:0], 16'h0198);
    check("quiet_gap", n_run[1][15:0], 16'h0000);
    check("restart", n_run[2][15:0], 16'h0008);
    @(posedge clk) packet_select <= 1'b0;
    tone_run(52, 52, 52);
    check("packet_zero", n_run[0][15:0], 16'h0010);
    @(posedge clk) packet_select <= 1'b1;
    wr(16'h0501);
    @(posedge clk) thermal_overload <= 1'b1;
    repeat (8) @(negedge clk);
    check("irq", {14'h0, thermal_flag, interrupt_out}, 16'h0003);
    wr(16'h0500);
    check("clr", {14'h0, thermal_flag, interrupt_out}, 16'h0000);
    u_host.send(16'h0401, 8);
    wr(16'h0230);
    check("part", cfg, 16'h2C03);
    check("q8", {7'h00, tx_gain_q8}, 16'h0100);
    @(posedge clk) shutdown_pin <= 1'b1;
    wr(16'h0401);
    check("halt", cfg, 16'h0000);
    @(posedge clk) shutdown_pin <= 1'b0;
    repeat (4) @(negedge clk);
    check("halt_rel", cfg, 16'h0000);
    wr(16'h0303);
    @(posedge clk) sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check("rerun", cfg, 16'h0000);
    results;
  end
endmodule // testbench
bind fe_core fe_core_asserts u_chk (.*);
